//--- hdl/sdi_ctrl.sv
`timescale 1ns/10ps
module sdi_ctrl (
	// Clock, reset, enable
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic        CE,
	// APB register port
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Memory access request
	input  wire logic        MEM_REQ,
	input  wire logic [31:0] MEM_ADDR,
	input  wire logic        MEM_WRITE,
	input  wire logic [1:0]  MEM_SIZE,
	output logic             MEM_ACK,
	// Memory pins
	output logic             SDRAM_CS_N,
	output logic             SDRAM_RAS_N,
	output logic             SDRAM_CAS_N,
	output logic             SDRAM_WE_N,
	output logic             SDRAM_CKE,
	output logic      [13:0] SDRAM_A,
	output logic      [1:0]  SDRAM_BA
);
	logic [15:0]            dram_control_reg;
	logic [31:0]            dram_address_control_reg;
	logic [31:0]            dram_address_mask_reg;
	sdi_pkg::sdi_state_e    state;
	sdi_pkg::sdi_state_e    next_state;
	logic [2:0]             cnt;
	logic [2:0]             next_cnt;
	logic [1:0]             beat;
	logic [1:0]             next_beat;
	logic                   ref_after;
	logic                   next_ref_after;
	logic                   refresh_req;
	logic                   cke;
	logic                   next_cke;
	logic [3:0]             next_cmd;
	logic [13:0]            next_a;
	logic [1:0]             next_ba;
	logic                   next_ack;
	logic                   ref_clear;
	logic                   clr_precharge;
	logic                   clr_mode_set;
	logic [12:0]            ref_cnt;
	logic [11:0]            startup_cnt;
	logic                   startup_done;

	// Register fields
	wire                    no_internal_mux_bit        = dram_control_reg[sdi_pkg::CTRL_NO_MUX_BIT];
	wire                    command_on_clock_enable_bit = dram_control_reg[sdi_pkg::CTRL_CMD_CKE_BIT];
	wire                    self_refresh_bit           = dram_control_reg[sdi_pkg::CTRL_SELF_BIT];
	wire [1:0]              refresh_to_activate_field  = dram_control_reg[sdi_pkg::CTRL_REFRESH_TO_ACTIVATE_FIELD_LSB +: 2];
	wire [8:0]              refresh_count_field        = dram_control_reg[sdi_pkg::CTRL_RC_LSB +: 9];
	wire                    refresh_enable_bit  = dram_address_control_reg[sdi_pkg::AC_REFRESH_EN_BIT];
	wire [1:0]              column_latency_field = dram_address_control_reg[sdi_pkg::AC_COLUMN_LATENCY_FIELD_LSB +: 2];
	wire [2:0]              command_bank_map_field = dram_address_control_reg[sdi_pkg::AC_CBM_LSB +: 3];
	wire                    mode_set_init_bit   = dram_address_control_reg[sdi_pkg::AC_MODE_SET_BIT];
	wire                    precharge_init_bit  = dram_address_control_reg[sdi_pkg::AC_PRECHARGE_BIT];
	wire [13:0]             base_address_mask_field = dram_address_mask_reg[31:sdi_pkg::BASE_LSB];
	wire                    mask_valid          = dram_address_mask_reg[sdi_pkg::AM_VALID_BIT];

	// APB decode
	wire                    apb_access = PSEL && PENABLE && !PREADY;
	wire                    apb_write  = PSEL && PENABLE && PREADY && PWRITE;
	wire                    sel_ctrl   = (PADDR == sdi_pkg::OFS_CONTROL);
	wire                    sel_ac     = (PADDR == sdi_pkg::OFS_ADDR_CTRL);
	wire                    sel_am     = (PADDR == sdi_pkg::OFS_ADDR_MASK);
	wire                    sel_stat   = (PADDR == sdi_pkg::OFS_STATUS);
	wire                    unmapped   = !(sel_ctrl || sel_ac || sel_am || sel_stat);
	wire [31:0]             status_word = {26'h0, self_refresh_bit && (state == sdi_pkg::ST_SELF),
	                                       refresh_req, !(state == sdi_pkg::ST_IDLE), startup_done,
	                                       mode_set_init_bit, precharge_init_bit};
	wire [31:0]             rdata = sel_ctrl ? {16'h0, dram_control_reg & sdi_pkg::CONTROL_WMASK} : // RULE_19
	                                sel_ac   ? dram_address_control_reg :
	                                sel_am   ? dram_address_mask_reg :
	                                sel_stat ? status_word : 32'h0;

	// Address decode and pin mapping
	wire                    in_space = mask_valid &&
	                          (((MEM_ADDR[31:sdi_pkg::BASE_LSB] ^ dram_address_control_reg[31:sdi_pkg::BASE_LSB])
	                            & ~base_address_mask_field) == 14'h0);
	wire [4:0]              bank_lsb = 5'(sdi_pkg::CMD_BIT_BASE + 1) + {2'b00, command_bank_map_field};
	wire [1:0]              bank     = MEM_ADDR[bank_lsb +: 2];
	wire [13:0]             flat_addr = MEM_ADDR[15:2];
	wire [13:0]             row_addr  = no_internal_mux_bit ? flat_addr : MEM_ADDR[23:10]; // RULE_14
	wire [1:0]              col_low   = MEM_ADDR[3:2] + beat;
	wire [13:0]             col_addr  = no_internal_mux_bit ? {flat_addr[13:2], col_low} // RULE_06
	                                                        : {6'h0, MEM_ADDR[9:4], col_low};
	wire [1:0]              last_beat = (MEM_SIZE == sdi_pkg::SIZE_16B) ? sdi_pkg::LAST_BEAT_16B : 2'd0;
	wire [2:0]              refresh_to_activate_field_wait = 3'(sdi_pkg::REFRESH_TO_ACTIVATE_FIELD_BASE - 1) + {1'b0, refresh_to_activate_field};
	wire [2:0]              trp_wait  = 3'(sdi_pkg::TRP_CYCLES);
	wire                    can_start = MEM_REQ && !MEM_ACK && startup_done; // RULE_01

	// Command sequencer
	always_comb begin
		next_state     = state;
		next_cnt       = cnt;
		next_beat      = beat;
		next_ref_after = ref_after;
		next_cke       = cke;
		next_cmd       = sdi_pkg::CMD_NOP;
		next_a         = SDRAM_A;
		next_ba        = SDRAM_BA;
		next_ack       = 1'b0;
		ref_clear      = 1'b0;
		clr_precharge  = 1'b0;
		clr_mode_set   = 1'b0;
		case (state)
			sdi_pkg::ST_IDLE: begin
				if (!startup_done) begin
					next_cmd = sdi_pkg::CMD_INHIBIT; // RULE_01
				end else if (self_refresh_bit) begin
					next_cmd   = sdi_pkg::CMD_REFRESH; // RULE_22
					next_cke   = 1'b0; // RULE_16
					next_state = sdi_pkg::ST_SELF;
				end else if (refresh_req) begin
					next_cmd       = sdi_pkg::CMD_PRECHARGE_ALL; // RULE_20
					next_a         = 14'h0400;
					next_ref_after = 1'b1;
					next_cnt       = trp_wait;
					next_state     = sdi_pkg::ST_PRE;
				end else if (can_start && !in_space) begin
					next_ack = 1'b1;
				end else if (can_start && mode_set_init_bit) begin
					next_cmd       = sdi_pkg::CMD_MODE_SET; // RULE_08 RULE_10 RULE_11
					next_a         = flat_addr; // RULE_09
					next_ba        = bank;
					clr_mode_set   = 1'b1;
					next_ref_after = 1'b0;
					next_cnt       = trp_wait;
					next_state     = sdi_pkg::ST_PRE;
				end else if (can_start && precharge_init_bit) begin
					next_cmd       = sdi_pkg::CMD_PRECHARGE_ALL; // RULE_03
					next_a         = 14'h0400;
					clr_precharge  = 1'b1;
					next_ref_after = 1'b0;
					next_cnt       = trp_wait;
					next_state     = sdi_pkg::ST_PRE;
				end else if (can_start) begin
					next_cmd   = sdi_pkg::CMD_ACTIVATE;
					next_a     = row_addr;
					next_ba    = bank;
					next_beat  = 2'd0;
					next_cnt   = {1'b0, column_latency_field}; // RULE_05
					next_state = sdi_pkg::ST_COL;
				end
			end
			sdi_pkg::ST_COL: begin
				// One column command per beat, each with a fresh address
				if (cnt != 3'd0) begin
					next_cnt = cnt - 3'd1;
				end else begin
					next_cmd = MEM_WRITE ? sdi_pkg::CMD_WRITE : sdi_pkg::CMD_READ; // RULE_06
					next_a   = col_addr;
					if (beat == last_beat) begin
						next_cnt   = {1'b0, column_latency_field}; // RULE_05
						next_state = sdi_pkg::ST_LAT;
					end else begin
						next_beat = beat + 2'd1;
					end
				end
			end
			sdi_pkg::ST_LAT: begin
				if (cnt != 3'd0) begin
					next_cnt = cnt - 3'd1;
				end else begin
					next_cmd       = sdi_pkg::CMD_PRECHARGE_ALL;
					next_a         = 14'h0400;
					next_ref_after = 1'b0;
					next_cnt       = trp_wait;
					next_state     = sdi_pkg::ST_PRE;
				end
			end
			sdi_pkg::ST_PRE: begin
				// Precharge time over: refresh or finish the access
				if (cnt != 3'd1) begin
					next_cnt = cnt - 3'd1;
				end else if (ref_after) begin
					next_cmd   = sdi_pkg::CMD_REFRESH; // RULE_20
					ref_clear  = 1'b1;
					next_cnt   = refresh_to_activate_field_wait; // RULE_17
					next_state = sdi_pkg::ST_REF;
				end else begin
					next_ack   = 1'b1;
					next_state = sdi_pkg::ST_IDLE;
				end
			end
			sdi_pkg::ST_REF: begin
				if (cnt != 3'd1) begin
					next_cnt = cnt - 3'd1; // RULE_21
				end else begin
					next_state = sdi_pkg::ST_IDLE;
				end
			end
			sdi_pkg::ST_SELF: begin
				// Leaving self-refresh raises the clock enable again
				if (!self_refresh_bit) begin
					next_cke   = 1'b1; // RULE_22
					next_state = sdi_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = sdi_pkg::ST_IDLE;
			end
		endcase
	end

	// Clock-enable pin: memory clock enable or command bit
	wire                    next_cke_pin = command_on_clock_enable_bit ? next_a[10] : next_cke; // RULE_15
	wire [12:0]             ref_reload   = {refresh_count_field, {sdi_pkg::REFRESH_UNIT_LOG2{1'b1}}}; // RULE_18
	wire                    ref_hit      = refresh_enable_bit && (ref_cnt == 13'h0);
	wire [15:0]             next_control = (dram_control_reg & ~sdi_pkg::CONTROL_WMASK)
	                                       | (PWDATA[15:0] & sdi_pkg::CONTROL_WMASK);
	wire [31:0]             ac_hw = dram_address_control_reg
	                                & ~({31'h0, clr_mode_set} << sdi_pkg::AC_MODE_SET_BIT)
	                                & ~({31'h0, clr_precharge} << sdi_pkg::AC_PRECHARGE_BIT);
	wire [31:0]             next_ac = (apb_write && sel_ac) ? (PWDATA & sdi_pkg::ADDR_CTRL_WMASK) : ac_hw;
	wire [31:0]             next_am = PWDATA & sdi_pkg::ADDR_MASK_WMASK;

	// APB slave
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h0;
		end else if (CE) begin
			PREADY  <= apb_access;
			PSLVERR <= apb_access && unmapped;
			PRDATA  <= apb_access ? rdata : 32'h0;
		end
	end

	// Registers
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			dram_control_reg         <= sdi_pkg::CONTROL_RESET;
			dram_address_control_reg <= sdi_pkg::ADDR_CTRL_RESET;
			dram_address_mask_reg    <= sdi_pkg::ADDR_MASK_RESET;
		end else if (CE) begin
			if (apb_write && sel_ctrl) begin
				dram_control_reg <= next_control;
			end
			// A software write wins over the self-clear of the init bits
			dram_address_control_reg <= next_ac;
			if (apb_write && sel_am) begin
				dram_address_mask_reg <= next_am;
			end
		end
	end

	// Refresh timer and start-up timer
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ref_cnt      <= 13'h0;
			refresh_req  <= 1'b0;
			startup_cnt  <= 12'h0;
			startup_done <= 1'b0;
		end else if (CE) begin
			ref_cnt      <= (!refresh_enable_bit || ref_hit) ? ref_reload : ref_cnt - 13'h1; // RULE_20
			// A refresh hit in the cycle of the clear keeps the request
			refresh_req  <= ref_hit || (refresh_req && !ref_clear);
			// Commands wait until the power-up period has run out
			startup_cnt  <= startup_done ? startup_cnt : startup_cnt + 12'h1;
			startup_done <= startup_done || (startup_cnt == 12'(sdi_pkg::STARTUP_CYCLES - 1)); // RULE_01
		end
	end

	// Sequencer state and pins
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			state       <= sdi_pkg::ST_IDLE;
			cnt         <= 3'h0;
			beat        <= 2'h0;
			ref_after   <= 1'b0;
			cke         <= 1'b1;
			MEM_ACK     <= 1'b0;
			{SDRAM_CS_N, SDRAM_RAS_N, SDRAM_CAS_N, SDRAM_WE_N} <= sdi_pkg::CMD_INHIBIT; // RULE_01
			SDRAM_CKE   <= 1'b1;
			SDRAM_A     <= 14'h0;
			SDRAM_BA    <= 2'h0;
		end else if (CE) begin
			state       <= next_state;
			cnt         <= next_cnt;
			beat        <= next_beat;
			ref_after   <= next_ref_after;
			cke         <= next_cke;
			MEM_ACK     <= next_ack;
			{SDRAM_CS_N, SDRAM_RAS_N, SDRAM_CAS_N, SDRAM_WE_N} <= next_cmd;
			SDRAM_CKE   <= next_cke_pin;
			SDRAM_A     <= next_a;
			SDRAM_BA    <= next_ba;
		end
	end
endmodule

//--- hdl/sdi_pkg.sv
// How it works
// (RULE_01) After reset all memory control outputs idle; no command before start-up time passes.
// (RULE_02) Software programs control, address-control and mask registers with commands disabled first.
// (RULE_03) Precharge-init set: next access in memory space issues precharge-all, then waits.
// (RULE_04) Software enables refresh and waits eight refreshes before mode register set.
// (RULE_05) Column latency of one, two or three clocks, from the latency field.
// (RULE_06) Bursts of 1, 2, 4 or 16 bytes; every beat gets address and command.
// (RULE_07) Memory mode register must be set to burst length one.
// (RULE_08) Mode-set-init set: next access in the space becomes a mode register set.
// (RULE_09) Mode register set drives the access address unmultiplexed onto the address pins.
// (RULE_10) A read or a write triggers the mode set; only its address matters.
// (RULE_11) Mode register set is issued in the first clock of the access.
// (RULE_12) Software widens the address mask for the mode set, then restores it.
// (RULE_13) Software sets the command/bank map field before the mode set.
// (RULE_14) Control bit 13 clear: row and column multiplexed internally onto address pins.
// (RULE_15) Control bit 12 clear: clock-enable pin is the memory clock enable.
// (RULE_16) Control bit 11 selects self-refresh.
// (RULE_17) Control bits 10:9 set refresh-to-activate gap; 00 gives three clocks.
// (RULE_18) Control bits 8:0 set refresh interval as (count+1)*16 clocks.
// (RULE_19) Control bits 15 and 14 read as zero.
// (RULE_20) Refresh counter hits zero, sets request, reloads; precharge, refresh, clear request.
// (RULE_21) Accesses arriving during a refresh cycle wait until it completes.
// (RULE_22) Setting self-refresh sends entry command; clearing it ends self-refresh.
package sdi_pkg;
	localparam logic [7:0]  OFS_CONTROL   = 8'h00;
	localparam logic [7:0]  OFS_ADDR_CTRL = 8'h04;
	localparam logic [7:0]  OFS_ADDR_MASK = 8'h08;
	localparam logic [7:0]  OFS_STATUS    = 8'h0c;
	localparam int          CTRL_NO_MUX_BIT   = 13;
	localparam int          CTRL_CMD_CKE_BIT  = 12;
	localparam int          CTRL_SELF_BIT     = 11;
	localparam int          CTRL_REFRESH_TO_ACTIVATE_FIELD_LSB     = 9;
	localparam int          CTRL_RC_LSB       = 0;
	localparam int          AC_REFRESH_EN_BIT = 15;
	localparam int          AC_COLUMN_LATENCY_FIELD_LSB       = 12;
	localparam int          AC_CBM_LSB        = 8;
	localparam int          AC_MODE_SET_BIT   = 6;
	localparam int          AC_PRECHARGE_BIT  = 3;
	localparam int          BASE_LSB          = 18;
	localparam int          AM_VALID_BIT      = 0;
	localparam logic [15:0] CONTROL_RESET     = 16'h0000;
	localparam logic [15:0] CONTROL_WMASK     = 16'h3fff;
	localparam logic [31:0] ADDR_CTRL_RESET   = 32'h0000_0000;
	localparam logic [31:0] ADDR_CTRL_WMASK   = 32'hfffc_b778;
	localparam logic [31:0] ADDR_MASK_RESET   = 32'h0000_0000;
	localparam logic [31:0] ADDR_MASK_WMASK   = 32'hfffc_017f;
	localparam int          CLK_PERIOD_PS     = 25000;
	localparam int          STARTUP_US        = 100;
	localparam int          STARTUP_CYCLES    = (STARTUP_US * 1000000) / CLK_PERIOD_PS;
	localparam int          TRP_NS            = 20;
	localparam int          TRP_CYCLES        = (TRP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int          REFRESH_UNIT_LOG2 = 4;
	localparam int          REFRESH_TO_ACTIVATE_FIELD_BASE         = 3;
	localparam int          CMD_BIT_BASE      = 17;
	localparam logic [1:0]  SIZE_16B          = 2'b11;
	localparam logic [1:0]  LAST_BEAT_16B     = 2'd3;
	localparam logic [3:0]  CMD_INHIBIT       = 4'hf;
	localparam logic [3:0]  CMD_NOP           = 4'h7;
	localparam logic [3:0]  CMD_ACTIVATE      = 4'h3;
	localparam logic [3:0]  CMD_READ          = 4'h5;
	localparam logic [3:0]  CMD_WRITE         = 4'h4;
	localparam logic [3:0]  CMD_PRECHARGE_ALL = 4'h2;
	localparam logic [3:0]  CMD_REFRESH       = 4'h1;
	localparam logic [3:0]  CMD_MODE_SET      = 4'h0;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_COL  = 6'h02,
		ST_LAT  = 6'h04,
		ST_PRE  = 6'h08,
		ST_REF  = 6'h10,
		ST_SELF = 6'h20
	} sdi_state_e;
endpackage

//--- testbench/sdi_ctrl_asserts.sv
`timescale 1ns/10ps
module sdi_ctrl_chk (
	// Clock, reset, enable
	input wire logic        CLK,
	input wire logic        RESET,
	input wire logic        CE,
	// Access side
	input wire logic        MEM_REQ,
	input wire logic [31:0] MEM_ADDR,
	input wire logic        MEM_ACK,
	// Memory pins
	input wire logic        SDRAM_CS_N,
	input wire logic        SDRAM_RAS_N,
	input wire logic        SDRAM_CAS_N,
	input wire logic        SDRAM_WE_N,
	input wire logic        SDRAM_CKE,
	input wire logic [13:0] SDRAM_A
);
	logic [3:0]  cmd;
	logic [12:0] up_cnt;
	wire         is_act  = cmd == sdi_pkg::CMD_ACTIVATE;
	wire         is_col  = cmd == sdi_pkg::CMD_READ || cmd == sdi_pkg::CMD_WRITE;
	wire         is_precharge_all_command = cmd == sdi_pkg::CMD_PRECHARGE_ALL;
	wire         is_ref  = cmd == sdi_pkg::CMD_REFRESH;
	wire         is_mode = cmd == sdi_pkg::CMD_MODE_SET;
	assign cmd = {SDRAM_CS_N, SDRAM_RAS_N, SDRAM_CAS_N, SDRAM_WE_N};
	// Cycles since reset release, saturating
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET)
			up_cnt <= 13'h0;
		else if (CE && up_cnt != 13'h1fff)
			up_cnt <= up_cnt + 13'h1;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	startup_idle_a: assert property (up_cnt < 13'hf96 |-> cmd == sdi_pkg::CMD_INHIBIT)
		else $error("memory command during start-up");
	precharge_all_command_a10_a: assert property (is_precharge_all_command |-> SDRAM_A[10])
		else $error("precharge-all without address bit 10");
	col_latency_a: assert property (is_act |-> ##[1:3] is_col)
		else $error("no column command within latency");
	burst_close_a: assert property (is_col |-> ##[1:6] is_precharge_all_command)
		else $error("burst not closed by precharge-all");
	refresh_gap_a: assert property (is_ref && SDRAM_CKE |=> !is_act [*2])
		else $error("activate too soon after refresh");
	refresh_precharge_all_command_a: assert property (is_ref && SDRAM_CKE |-> $past(is_precharge_all_command))
		else $error("refresh not preceded by precharge-all");
	mode_addr_a: assert property (is_mode |-> MEM_REQ && SDRAM_A == MEM_ADDR[15:2])
		else $error("mode set address wrong");
	mode_ack_a: assert property (is_mode |-> !MEM_ACK ##1 MEM_ACK)
		else $error("mode set not in first clock of access");
	cke_drop_a: assert property ($fell(SDRAM_CKE) |-> is_ref || !SDRAM_A[10])
		else $error("clock enable dropped without cause");
endmodule

bind sdi_ctrl sdi_ctrl_chk chk (.CLK(CLK), .RESET(RESET), .CE(CE), .MEM_REQ(MEM_REQ),
	.MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK), .SDRAM_CS_N(SDRAM_CS_N), .SDRAM_RAS_N(SDRAM_RAS_N),
	.SDRAM_CAS_N(SDRAM_CAS_N), .SDRAM_WE_N(SDRAM_WE_N), .SDRAM_CKE(SDRAM_CKE), .SDRAM_A(SDRAM_A));

//--- testbench/sdi_mem_model.sv
`timescale 1ns/10ps
module sdi_mem_model (
	// Clock
	input wire logic        clk,
	// Command pins
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic        cke,
	input wire logic [13:0] addr
);
	logic [3:0]  cmd;
	logic [13:0] row;
	logic [13:0] mode_reg;
	logic        act_cke;
	logic        mode_bad = 1'b0;
	int          cyc, act_cyc, act_gap, beats, ref_cyc, ref_gap, refs, modes;
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	// Records what the memory sees; it has no data pins to answer on
	always @(posedge clk) begin
		cyc++;
		if (cmd == sdi_pkg::CMD_ACTIVATE) begin
			row = addr;
			act_cyc = cyc;
			act_cke = cke;
			beats = 0;
		end
		if (cmd == sdi_pkg::CMD_READ || cmd == sdi_pkg::CMD_WRITE) begin
			if (beats == 0)
				act_gap = cyc - act_cyc;
			beats++;
		end
		if (cmd == sdi_pkg::CMD_REFRESH && cke) begin
			ref_gap = cyc - ref_cyc;
			ref_cyc = cyc;
			refs++;
		end
		// Mode set needs burst length one and enough refreshes first
		if (cmd == sdi_pkg::CMD_MODE_SET) begin
			mode_reg = addr;
			modes++;
			mode_bad = mode_bad || addr[2:0] != 3'h0 || refs < 8;
		end
	end
endmodule

//--- testbench/test_sdram_init_and_mode_set.sv
`timescale 1ns/10ps
module test_sdram_init_and_mode_set;
	logic        clk, reset, ce, psel, penable, pwrite, pready, pslverr, er;
	logic        mem_req, mem_write, mem_ack, cs_n, ras_n, cas_n, we_n, cke;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, mem_addr;
	logic [1:0]  mem_size, ba;
	logic [13:0] sa;
	logic [72:0] rows [4];
	int          err_total, comparisons;
	time         t0;

	sdi_ctrl dut (.CLK(clk), .RESET(reset), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.MEM_REQ(mem_req), .MEM_ADDR(mem_addr), .MEM_WRITE(mem_write), .MEM_SIZE(mem_size),
		.MEM_ACK(mem_ack), .SDRAM_CS_N(cs_n), .SDRAM_RAS_N(ras_n), .SDRAM_CAS_N(cas_n),
		.SDRAM_WE_N(we_n), .SDRAM_CKE(cke), .SDRAM_A(sa), .SDRAM_BA(ba));
	sdi_mem_model mem (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.cke(cke), .addr(sa));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task complete_run;
		if (err_total == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task acc(input logic [31:0] a, input logic w, input logic [1:0] s);
		@(posedge clk);
		mem_req <= 1'b1;
		mem_addr <= a;
		mem_write <= w;
		mem_size <= s;
		do @(posedge clk); while (mem_ack !== 1'b1);
		mem_req <= 1'b0;
	endtask

	initial begin
		err_total = 0;
		comparisons = 0;
		{ce, reset} = 2'b11;
		{psel, penable, pwrite, paddr, pwdata} = 43'h0;
		{mem_req, mem_write, mem_size, mem_addr} = 36'h0;
		rows[0] = {8'h00, 32'hffff_f7ff, 32'h0000_37ff, 1'b0};
		rows[1] = {8'h04, 32'hffff_ffff, 32'hfffc_b778, 1'b0};
		rows[2] = {8'h08, 32'hffff_ffff, 32'hfffc_017f, 1'b0};
		rows[3] = {8'h10, 32'hffff_ffff, 32'h0000_0000, 1'b1};
		repeat (6) @(posedge clk);
		chk({cs_n, ras_n, cas_n, we_n, cke}, 32'h1f);
		reset <= 1'b0;
		t0 = $time;
		foreach (rows[i]) begin
			apb(1'b0, rows[i][72:65], 32'h0);
			chk(rd, 32'h0);
			apb(1'b1, rows[i][72:65], rows[i][64:33]);
			apb(1'b0, rows[i][72:65], 32'h0);
			chk(rd, rows[i][32:1]);
			chk(er, rows[i][0]);
		end
		// Operating set-up with refresh off, then a precharge-all access that waits for start-up to end
		apb(1'b1, 8'h00, 32'h0000_0002);
		apb(1'b1, 8'h08, 32'hfffc_0001);
		apb(1'b1, 8'h04, 32'h0000_0308);
		acc(32'h0, 1'b0, 2'b10);
		chk(($time - t0) / 25 > 3990, 32'h1);
		chk(mem.act_cyc, 32'h0);
		apb(1'b1, 8'h04, 32'h0000_8300);
		repeat (450) @(posedge clk);
		chk(mem.refs >= 8, 32'h1);
		chk(mem.ref_gap, 32'h30);
		// Mode set blocked by the mask, then mask widened
		apb(1'b1, 8'h08, 32'h0000_0000);
		apb(1'b1, 8'h04, 32'h0000_8340);
		acc(32'h80, 1'b0, 2'b10);
		chk(mem.modes, 32'h0);
		apb(1'b1, 8'h08, 32'hfffc_0001);
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, 8'h04, 32'h0000_8340);
			acc(32'h80 + i * 32'h40, i[0], 2'b10);
			chk(mem.modes, i + 1);
			chk(mem.mode_reg, 32'h20 + i * 32'h10);
			chk(mem.mode_bad, 32'h0);
		end
		for (int l = 0; l < 3; l++)
			for (int s = 0; s < 4; s++) begin
				apb(1'b1, 8'h04, 32'h0000_8300 | (l << 12));
				acc(32'h0012_3450, s[0], s[1:0]);
				chk(mem.act_gap, l + 1);
				chk(mem.beats, s == 3 ? 32'h4 : 32'h1);
				chk(mem.row, 32'h048d);
			end
		apb(1'b1, 8'h00, 32'h0000_1002);
		acc(32'h0000_0400, 1'b0, 2'b10);
		chk(mem.act_cke, 32'h0);
		apb(1'b1, 8'h00, 32'h0000_0002);
		acc(32'h0000_0400, 1'b0, 2'b10);
		chk(mem.act_cke, 32'h1);
		apb(1'b1, 8'h00, 32'h0000_0802);
		repeat (12) @(posedge clk);
		chk(cke, 32'h0);
		apb(1'b1, 8'h00, 32'h0000_0002);
		repeat (12) @(posedge clk);
		chk(cke, 32'h1);
		acc(32'h0000_0400, 1'b1, 2'b00);
		chk(mem.beats, 32'h1);
		// Reset in mid-run: pins idle, address-control register and start-up timer cleared
		reset <= 1'b1;
		@(posedge clk);
		chk({cs_n, ras_n, cas_n, we_n, cke}, 32'h1f);
		reset <= 1'b0;
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0);
		complete_run();
	end

	initial begin
		#500000;
		err_total++;
		complete_run();
	end
endmodule
